// >>> hdl/safe_stop_monitor_consts.svh
// constants and overview for the single-axis safe stop monitor
`ifndef SAFE_STOP_MONITOR_CONSTS_SVH
`define SAFE_STOP_MONITOR_CONSTS_SVH
`define SSM_CLK_HZ        125000000
`define SSM_MON_TICK_NS   2000000
`define SSM_MON_TICK_CYC  ((`SSM_MON_TICK_NS / 8) > 0 ? (`SSM_MON_TICK_NS / 8) : 1)
`define SSM_POS_W         32
`define SSM_DLY_W         16
`define SSM_FB_TICKS      1
// synchroniser reset matches idle pins: link alive, functions deselected
`define SSM_SYNC_RST      8'h22
`endif

// >>> hdl/safe_stop_monitor_pkg.sv
// types of the safe stop monitor
package safe_stop_monitor_pkg;
	typedef enum logic [1:0] {
		PATH_IDLE,
		PATH_WAIT,
		PATH_CHECK,
		PATH_FAULT
	} path_st_t;

	typedef struct packed {
		logic cancel_req;
		logic brake_en;
		logic feedback;
	} path_in_t;

	typedef struct packed {
		logic pulses_off;
		logic brake_on;
		logic fb_ok;
		logic fb_fault;
	} path_out_t;

	typedef enum logic [1:0] {
		SEL_OFF,
		SEL_REDUCED,
		SEL_DELAY,
		SEL_STOP
	} sel_st_t;
endpackage

// >>> hdl/shutdown_path.sv
// one pulse-cancellation shutdown path with feedback check and brake control
`timescale 1ns/1ps
`default_nettype none
module shutdown_path
	import safe_stop_monitor_pkg::*;
(
	// clock and reset
	input  wire logic      mclk_i,
	input  wire logic      rst_i,
	input  wire logic      tick_i,
	// path control
	input  wire path_in_t  ctl_i,
	output path_out_t      stat_o
);
	typedef struct packed {
		path_st_t  st;
		logic      armed;
		path_out_t o;
	} sp_state_t;

	sp_state_t cur_ff;
	sp_state_t nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.o.brake_on = ctl_i.cancel_req & ctl_i.brake_en;
		case (cur_ff.st)
			PATH_IDLE: begin
				nxt_cur.o.fb_ok = 1'b0;
				nxt_cur.armed   = 1'b0;
				if (ctl_i.cancel_req) begin
					nxt_cur.o.pulses_off = 1'b1;
					nxt_cur.st           = PATH_WAIT;
				end else begin
					nxt_cur.o.pulses_off = 1'b0;
				end
			end
			PATH_WAIT: begin
				// a full monitoring cycle covers stage lag and the feedback synchroniser
				if (tick_i && cur_ff.armed)
					nxt_cur.st = PATH_CHECK;
				else if (tick_i)
					nxt_cur.armed = 1'b1;
			end
			PATH_CHECK: begin
				if (ctl_i.feedback) begin
					nxt_cur.o.fb_ok = 1'b1;
				end else begin
					nxt_cur.o.fb_fault = 1'b1;
				end
				nxt_cur.st = PATH_FAULT;
			end
			PATH_FAULT: begin
				if (!ctl_i.cancel_req) begin
					nxt_cur.st           = PATH_IDLE;
					nxt_cur.o.pulses_off = 1'b0;
					nxt_cur.o.fb_ok      = 1'b0;
					nxt_cur.o.fb_fault   = 1'b0;
				end
			end
			default: nxt_cur.st = PATH_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	assign stat_o = cur_ff.o;

	property p_fb_after_tick;
		@(posedge mclk_i) disable iff (rst_i)
			(cur_ff.st == PATH_WAIT && cur_ff.armed && tick_i) |=> ##1 (stat_o.fb_ok | stat_o.fb_fault);
	endproperty
	a_fb_after_tick: assert property (p_fb_after_tick) else $error("feedback not checked");

	property p_brake;
		@(posedge mclk_i) disable iff (rst_i)
			(ctl_i.cancel_req && ctl_i.brake_en) |=> stat_o.brake_on;
	endproperty
	a_brake: assert property (p_brake) else $error("brake not applied");
endmodule // shutdown_path
`default_nettype wire

// >>> hdl/safe_stop_monitor.sv
// safe stop monitor: two shutdown paths, test stop and operating stop selection
`timescale 1ns/1ps
`default_nettype none
`include "safe_stop_monitor_consts.svh"
module safe_stop_monitor
	import safe_stop_monitor_pkg::*;
#(
	parameter int POS_W = `SSM_POS_W,
	parameter int DLY_W = `SSM_DLY_W,
	parameter int TICK_CYC = `SSM_MON_TICK_CYC
)(
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	// shutdown requests
	input  wire logic             cu_cancel_req_i,
	input  wire logic             pm_cancel_req_i,
	input  wire logic             ctrl_link_ok_i,
	input  wire logic             cu_brake_ctrl_enable_i,
	input  wire logic             pm_brake_ctrl_enable_i,
	input  wire logic             cu_feedback_i,
	input  wire logic             pm_feedback_i,
	input  wire logic             test_stop_safety_input_i,
	// operating stop selection
	input  wire logic             combined_deselect_i,
	input  wire logic             stop_deselect_i,
	input  wire logic             internal_stop_cde_i,
	input  wire logic [1:0]       reduced_stage_i,
	input  wire logic [DLY_W-1:0] changeover_delay_drive_i,
	input  wire logic [POS_W-1:0] standstill_window_drive_i,
	input  wire logic [POS_W-1:0] actual_position_i,
	// outputs
	output logic                  cu_pulses_off_o,
	output logic                  pm_pulses_off_o,
	output logic                  cu_brake_o,
	output logic                  pm_brake_o,
	output logic                  feedback_fault_o,
	output logic                  pulses_cancelled_safety_output_o,
	output logic                  test_running_o,
	output logic                  safe_operating_stop_active_o,
	output logic [1:0]            reduced_stage_safety_output_o,
	output logic                  stop_b_request_o,
	output logic                  stop_a_request_o,
	output logic                  standstill_violation_fault_o
);
	if (TICK_CYC < 1 || POS_W < 2 || DLY_W < 1) begin : g_bad_params
		$error("safe_stop_monitor: bad parameters");
	end

	// pin synchronisers: two flops, only second stage read
	localparam int NSYNC = 8;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	assign raw_in = {cu_cancel_req_i, pm_cancel_req_i, ctrl_link_ok_i, cu_feedback_i,
	                 pm_feedback_i, test_stop_safety_input_i, combined_deselect_i, stop_deselect_i};
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_ff <= `SSM_SYNC_RST;
			sync2_ff <= `SSM_SYNC_RST;
		end else begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
		end
	end
	logic s_cu_req;
	logic s_pm_req;
	logic s_link_ok;
	logic s_cu_fb;
	logic s_pm_fb;
	logic s_test;
	logic s_comb;
	logic s_stopdes;
	assign {s_cu_req, s_pm_req, s_link_ok, s_cu_fb, s_pm_fb, s_test, s_comb, s_stopdes} = sync2_ff;

	typedef struct packed {
		logic [31:0]      tick_cnt;
		logic             tick;
		logic             test_run;
		logic             test_prev;
		sel_st_t          sel;
		logic             was_reduced;
		logic [DLY_W-1:0] dly_cnt;
		logic [POS_W-1:0] pos_latch;
		logic             violation;
		logic             stop_b;
		logic             stop_a;
	} top_state_t;

	top_state_t st_ff;
	top_state_t nxt_st;

	path_in_t  cu_in;
	path_in_t  pm_in;
	path_out_t cu_out;
	path_out_t pm_out;

	// test stop drives both paths at once, independent of standard cancellation
	always_comb begin
		cu_in.cancel_req = s_cu_req | st_ff.test_run | st_ff.stop_a;
		cu_in.brake_en   = cu_brake_ctrl_enable_i;
		cu_in.feedback   = s_cu_fb;
		pm_in.cancel_req = s_pm_req | ~s_link_ok | st_ff.test_run | st_ff.stop_a;
		pm_in.brake_en   = pm_brake_ctrl_enable_i;
		pm_in.feedback   = s_pm_fb;
	end

	shutdown_path u_cu_path (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.tick_i (st_ff.tick),
		.ctl_i  (cu_in),
		.stat_o (cu_out)
	);

	shutdown_path u_pm_path (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.tick_i (st_ff.tick),
		.ctl_i  (pm_in),
		.stat_o (pm_out)
	);

	logic             eff_comb;
	logic             eff_stopdes;
	logic [POS_W-1:0] dev;

	always_comb begin
		nxt_st = st_ff;
		// monitoring tick divider
		if (st_ff.tick_cnt >= 32'(TICK_CYC - 1)) begin
			nxt_st.tick_cnt = 32'h0000_0000;
			nxt_st.tick     = 1'b1;
		end else begin
			nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
			nxt_st.tick     = 1'b0;
		end
		// test stop: rising edge of the shared drive safety input starts it
		nxt_st.test_prev = s_test;
		if (s_test && !st_ff.test_prev)
			nxt_st.test_run = 1'b1;
		else if (!s_test)
			nxt_st.test_run = 1'b0;
		// selection decode, internal C/D/E forces both inputs low
		eff_comb    = s_comb & ~internal_stop_cde_i;
		eff_stopdes = s_stopdes & ~internal_stop_cde_i;
		dev = (actual_position_i >= st_ff.pos_latch) ? actual_position_i - st_ff.pos_latch
		                                             : st_ff.pos_latch - actual_position_i;
		case (st_ff.sel)
			SEL_OFF: begin
				nxt_st.was_reduced = 1'b0;
				if (!eff_comb && eff_stopdes) begin
					nxt_st.sel = SEL_REDUCED;
				end else if (!eff_comb) begin
					nxt_st.sel       = SEL_STOP;
					nxt_st.pos_latch = actual_position_i;
					nxt_st.stop_b    = 1'b1;
				end
			end
			SEL_REDUCED: begin
				nxt_st.was_reduced = 1'b1;
				if (eff_comb) begin
					nxt_st.sel = SEL_OFF;
				end else if (!eff_stopdes) begin
					nxt_st.sel     = SEL_DELAY;
					nxt_st.dly_cnt = changeover_delay_drive_i;
				end
			end
			SEL_DELAY: begin
				if (eff_comb) begin
					nxt_st.sel = SEL_OFF;
				end else if (eff_stopdes) begin
					nxt_st.sel = SEL_REDUCED;
				end else if (st_ff.tick) begin
					if (st_ff.dly_cnt == '0) begin
						nxt_st.sel       = SEL_STOP;
						nxt_st.pos_latch = actual_position_i;
					end else begin
						nxt_st.dly_cnt = st_ff.dly_cnt - 1'b1;
					end
				end
			end
			SEL_STOP: begin
				if (eff_comb) begin
					nxt_st.sel = SEL_OFF;
				end else if (eff_stopdes) begin
					nxt_st.sel = SEL_REDUCED;
				end else if (st_ff.tick && dev > standstill_window_drive_i) begin
					nxt_st.violation = 1'b1;
					nxt_st.stop_b    = 1'b1;
				end
			end
			default: nxt_st.sel = SEL_OFF;
		endcase
		// stop B hands over to stop A on the next monitoring tick
		if (st_ff.stop_b && st_ff.tick)
			nxt_st.stop_a = 1'b1;
		if (eff_comb && !st_ff.violation) begin
			nxt_st.stop_b = 1'b0;
			nxt_st.stop_a = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	always_comb begin
		cu_pulses_off_o                  = cu_out.pulses_off;
		pm_pulses_off_o                  = pm_out.pulses_off;
		cu_brake_o                       = cu_out.brake_on;
		pm_brake_o                       = pm_out.brake_on;
		feedback_fault_o                 = cu_out.fb_fault | pm_out.fb_fault;
		pulses_cancelled_safety_output_o = cu_out.fb_ok & pm_out.fb_ok;
		test_running_o                   = st_ff.test_run;
		safe_operating_stop_active_o     = (st_ff.sel == SEL_STOP);
		reduced_stage_safety_output_o    = (st_ff.sel == SEL_REDUCED) ? reduced_stage_i : 2'h0;
		stop_b_request_o                 = st_ff.stop_b;
		stop_a_request_o                 = st_ff.stop_a;
		standstill_violation_fault_o     = st_ff.violation;
	end

	property p_test_both_paths;
		@(posedge mclk_i) disable iff (rst_i)
			test_running_o |=> (cu_pulses_off_o && pm_pulses_off_o);
	endproperty
	a_test_both_paths: assert property (p_test_both_paths) else $error("test stop missed a path");

	property p_link_loss;
		@(posedge mclk_i) disable iff (rst_i)
			!s_link_ok |=> pm_pulses_off_o;
	endproperty
	a_link_loss: assert property (p_link_loss) else $error("no torque off on link loss");

	property p_decode_off;
		@(posedge mclk_i) disable iff (rst_i)
			(eff_comb && st_ff.sel != SEL_OFF) |=> !safe_operating_stop_active_o;
	endproperty
	a_decode_off: assert property (p_decode_off) else $error("combined deselect ignored");

	property p_reduced_off;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel == SEL_STOP && !eff_comb && eff_stopdes) |=> st_ff.sel == SEL_REDUCED;
	endproperty
	a_reduced_off: assert property (p_reduced_off) else $error("reduced speed kept stop");

	property p_delay_first;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel == SEL_REDUCED && !eff_comb && !eff_stopdes) |=> !safe_operating_stop_active_o;
	endproperty
	a_delay_first: assert property (p_delay_first) else $error("stop active before delay");

	property p_violation;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel == SEL_STOP && st_ff.tick && !eff_comb && !eff_stopdes
			 && dev > standstill_window_drive_i) |=> (standstill_violation_fault_o && stop_b_request_o);
	endproperty
	a_violation: assert property (p_violation) else $error("violation not flagged");

	property p_stage;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel != SEL_REDUCED) |-> reduced_stage_safety_output_o == 2'h0;
	endproperty
	a_stage: assert property (p_stage) else $error("stage shown outside reduced speed");

	property p_test_flag;
		@(posedge mclk_i) disable iff (rst_i)
			(s_test && !st_ff.test_prev) |=> test_running_o;
	endproperty
	a_test_flag: assert property (p_test_flag) else $error("test flag missing");

	property p_test_end;
		@(posedge mclk_i) disable iff (rst_i)
			!s_test |=> !test_running_o;
	endproperty
	a_test_end: assert property (p_test_end) else $error("test flag outlived input");

	property p_test_indep;
		@(posedge mclk_i) disable iff (rst_i)
			(test_running_o && !s_cu_req) |=> cu_pulses_off_o;
	endproperty
	a_test_indep: assert property (p_test_indep) else $error("test stop needs standard request");

	property p_cu_cancel;
		@(posedge mclk_i) disable iff (rst_i)
			s_cu_req |=> cu_pulses_off_o;
	endproperty
	a_cu_cancel: assert property (p_cu_cancel) else $error("cu request not cancelling");

	property p_pm_cancel;
		@(posedge mclk_i) disable iff (rst_i)
			s_pm_req |=> pm_pulses_off_o;
	endproperty
	a_pm_cancel: assert property (p_pm_cancel) else $error("pm request not cancelling");

	property p_cde_reduced;
		@(posedge mclk_i) disable iff (rst_i)
			(internal_stop_cde_i && st_ff.sel == SEL_REDUCED) |=> st_ff.sel == SEL_DELAY;
	endproperty
	a_cde_reduced: assert property (p_cde_reduced) else $error("internal stop did not force change");

	property p_cde_hold;
		@(posedge mclk_i) disable iff (rst_i)
			(internal_stop_cde_i && st_ff.sel == SEL_STOP) |=> safe_operating_stop_active_o;
	endproperty
	a_cde_hold: assert property (p_cde_hold) else $error("internal stop released operating stop");

	property p_direct_stop;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel == SEL_OFF && !eff_comb && !eff_stopdes) |=> (safe_operating_stop_active_o && stop_b_request_o);
	endproperty
	a_direct_stop: assert property (p_direct_stop) else $error("direct selection without stop b");

	property p_stop_a;
		@(posedge mclk_i) disable iff (rst_i)
			(stop_b_request_o && st_ff.tick && !eff_comb) |=> stop_a_request_o;
	endproperty
	a_stop_a: assert property (p_stop_a) else $error("stop a did not follow stop b");

	property p_delay_load;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel == SEL_REDUCED && !eff_comb && !eff_stopdes) |=> st_ff.dly_cnt == $past(changeover_delay_drive_i);
	endproperty
	a_delay_load: assert property (p_delay_load) else $error("changeover delay not loaded");

	property p_delay_hold;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel == SEL_DELAY && !(st_ff.tick && st_ff.dly_cnt == '0)) |=> !safe_operating_stop_active_o;
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("stop active before delay expired");

	property p_latch;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel == SEL_DELAY && st_ff.tick && st_ff.dly_cnt == '0 && !eff_comb && !eff_stopdes)
			|=> (safe_operating_stop_active_o && st_ff.pos_latch == $past(actual_position_i));
	endproperty
	a_latch: assert property (p_latch) else $error("position not latched at activation");

	property p_window_ok;
		@(posedge mclk_i) disable iff (rst_i)
			(st_ff.sel == SEL_STOP && st_ff.tick && dev <= standstill_window_drive_i && !st_ff.violation)
			|=> !standstill_violation_fault_o;
	endproperty
	a_window_ok: assert property (p_window_ok) else $error("violation inside window");

	property p_violation_sticky;
		@(posedge mclk_i) disable iff (rst_i)
			standstill_violation_fault_o |=> standstill_violation_fault_o;
	endproperty
	a_violation_sticky: assert property (p_violation_sticky) else $error("violation alarm dropped");
endmodule // safe_stop_monitor
`default_nettype wire

// >>> tb/drive_stage_model.sv
// power stage model answering pulse cancellation with feedback on both shutdown paths
`timescale 1ns/1ps
`default_nettype none
module drive_stage_model (
	// clock
	input  wire logic mclk_i,
	// pulse cancellation from both paths
	input  wire logic cu_off_i,
	input  wire logic pm_off_i,
	input  wire logic fail_i,
	// feedback back to the monitor
	output logic      cu_fb_o,
	output logic      pm_fb_o
);
	initial begin
		cu_fb_o = 1'b0;
		pm_fb_o = 1'b0;
	end
	// feedback lags the stage by one cycle; a broken stage never confirms
	always @(posedge mclk_i) begin
		cu_fb_o <= cu_off_i & ~fail_i;
		pm_fb_o <= pm_off_i & ~fail_i;
	end
endmodule // drive_stage_model
`default_nettype wire

// >>> tb/safe_stop_monitor_test.sv
// self-checking bench of the safe stop monitor
`timescale 1ns/1ps
`default_nettype none
module safe_stop_monitor_test
	import safe_stop_monitor_pkg::*;
;
	logic        mclk_i = 1'b0, rst_i = 1'b1, fail = 1'b0;
	logic        cu_cancel_req_i = 1'b0, pm_cancel_req_i = 1'b0, ctrl_link_ok_i = 1'b1;
	logic        cu_brake_ctrl_enable_i = 1'b0, pm_brake_ctrl_enable_i = 1'b0;
	logic        cu_feedback_i, pm_feedback_i, test_stop_safety_input_i = 1'b0;
	logic        combined_deselect_i = 1'b1, stop_deselect_i = 1'b0, internal_stop_cde_i = 1'b0;
	logic [1:0]  reduced_stage_i = 2'h0;
	logic [15:0] changeover_delay_drive_i = 16'h0003;
	logic [31:0] standstill_window_drive_i = 32'h0000_000a, actual_position_i = 32'h0000_0100;
	logic        cu_pulses_off_o, pm_pulses_off_o, cu_brake_o, pm_brake_o, feedback_fault_o;
	logic        pulses_cancelled_safety_output_o, test_running_o, safe_operating_stop_active_o;
	logic [1:0]  reduced_stage_safety_output_o;
	logic        stop_b_request_o, stop_a_request_o, standstill_violation_fault_o;
	int          num_errors = 0, num_checks = 0, cyc = 0;

	always #4 mclk_i = ~mclk_i;

	safe_stop_monitor #(.POS_W(32), .DLY_W(16), .TICK_CYC(4)) u_dut (.mclk_i, .rst_i, .cu_cancel_req_i,
		.pm_cancel_req_i, .ctrl_link_ok_i, .cu_brake_ctrl_enable_i, .pm_brake_ctrl_enable_i, .cu_feedback_i,
		.pm_feedback_i, .test_stop_safety_input_i, .combined_deselect_i, .stop_deselect_i, .internal_stop_cde_i,
		.reduced_stage_i, .changeover_delay_drive_i, .standstill_window_drive_i, .actual_position_i,
		.cu_pulses_off_o, .pm_pulses_off_o, .cu_brake_o, .pm_brake_o, .feedback_fault_o,
		.pulses_cancelled_safety_output_o, .test_running_o, .safe_operating_stop_active_o,
		.reduced_stage_safety_output_o, .stop_b_request_o, .stop_a_request_o, .standstill_violation_fault_o);

	drive_stage_model u_stage (.mclk_i, .cu_off_i(cu_pulses_off_o), .pm_off_i(pm_pulses_off_o), .fail_i(fail),
		.cu_fb_o(cu_feedback_i), .pm_fb_o(pm_feedback_i));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic cyc_wait(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	task automatic do_reset();
		rst_i = 1'b1;
		cyc_wait(2);
		rst_i = 1'b0;
		cyc_wait(1);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// cancel request on one path, with or without a working stage
	task automatic t_path(input bit pm, input bit brk, input bit bad);
		fail = bad;
		cu_brake_ctrl_enable_i = brk;
		pm_brake_ctrl_enable_i = brk;
		if (pm)
			pm_cancel_req_i = 1'b1;
		else
			cu_cancel_req_i = 1'b1;
		cyc_wait(3);
		chk(pm ? pm_pulses_off_o : cu_pulses_off_o, 1, "pulses off");
		chk(pm ? pm_brake_o : cu_brake_o, brk, "brake");
		cyc_wait(12);
		chk(feedback_fault_o, bad, "feedback fault");
		cu_cancel_req_i = 1'b0;
		pm_cancel_req_i = 1'b0;
		fail = 1'b0;
		cyc_wait(12);
		chk(feedback_fault_o, 0, "fault release");
		$display("path test done pm=%0d brk=%0d bad=%0d", pm, brk, bad);
	endtask

	task automatic t_link();
		ctrl_link_ok_i = 1'b0;
		cyc_wait(5);
		chk(pm_pulses_off_o, 1, "link loss");
		ctrl_link_ok_i = 1'b1;
		cyc_wait(12);
		$display("link loss test done");
	endtask

	task automatic t_test_stop();
		chk({cu_pulses_off_o, pm_pulses_off_o}, 2'b00, "pulses enabled at start");
		cu_brake_ctrl_enable_i = 1'b1;
		pm_brake_ctrl_enable_i = 1'b1;
		test_stop_safety_input_i = 1'b1;
		cyc_wait(16);
		chk({cu_pulses_off_o, pm_pulses_off_o}, 2'b11, "both paths");
		chk({cu_brake_o, pm_brake_o}, 2'b11, "brake on test");
		chk(pulses_cancelled_safety_output_o, 1, "ack");
		chk(test_running_o, 1, "running");
		test_stop_safety_input_i = 1'b0;
		cyc_wait(12);
		chk(test_running_o, 0, "running end");
		$display("test stop done");
	endtask

	task automatic t_decode();
		combined_deselect_i = 1'b0;
		stop_deselect_i = 1'b1;
		for (int s = 0; s < 4; s++) begin
			reduced_stage_i = 2'(s);
			cyc_wait(6);
			chk(reduced_stage_safety_output_o, s, "stage");
			chk(safe_operating_stop_active_o, 0, "reduced");
		end
		combined_deselect_i = 1'b1;
		cyc_wait(6);
		chk(safe_operating_stop_active_o, 0, "deselected");
		$display("decode test done");
	endtask

	// reduced speed to stop with changeover delay, then a window breach
	task automatic t_changeover(input bit internal);
		combined_deselect_i = 1'b0;
		stop_deselect_i = 1'b1;
		cyc_wait(8);
		if (internal)
			internal_stop_cde_i = 1'b1;
		else
			stop_deselect_i = 1'b0;
		cyc_wait(6);
		chk(safe_operating_stop_active_o, 0, "delay running");
		cyc_wait(16);
		chk(safe_operating_stop_active_o, 1, "stop active");
		actual_position_i = 32'h0000_010a;
		cyc_wait(12);
		chk(standstill_violation_fault_o, 0, "inside window");
		actual_position_i = 32'h0000_00f5;
		cyc_wait(12);
		chk(standstill_violation_fault_o, 1, "outside window");
		chk(stop_b_request_o, 1, "stop b");
		cyc_wait(8);
		chk(stop_a_request_o, 1, "stop a");
		internal_stop_cde_i = 1'b0;
		actual_position_i = 32'h0000_0100;
		combined_deselect_i = 1'b1;
		do_reset();
		$display("changeover test done internal=%0d", internal);
	endtask

	task automatic t_direct();
		stop_deselect_i = 1'b0;
		combined_deselect_i = 1'b0;
		cyc_wait(12);
		chk(stop_b_request_o, 1, "direct stop b");
		cyc_wait(8);
		chk(stop_a_request_o, 1, "direct stop a");
		combined_deselect_i = 1'b1;
		do_reset();
		$display("direct select test done");
	endtask

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		do_reset();
		chk({cu_pulses_off_o, pm_pulses_off_o, test_running_o, stop_b_request_o}, 0, "reset");
		t_path(0, 1, 0);
		t_path(1, 0, 1);
		t_link();
		t_test_stop();
		t_decode();
		t_changeover(0);
		t_changeover(1);
		t_direct();
		conclude();
	end
endmodule // safe_stop_monitor_test
`default_nettype wire
